// [verilog/vic_pkg.sv]
`default_nettype none
package vic_pkg;
    // widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int VEC_W = 7;
    localparam int PC_W = 24;
    localparam int LVL_W = 4;
    localparam int PRI_W = 3;
    localparam int NUM_TRAPS = 8;
    localparam int SRC_PER_WORD = 16;
    localparam int SRC_PER_PRI = 4;
    localparam int PRI_FIELD_STRIDE = 4;
    // register offsets
    localparam logic [3:0] GRP_FLAG = 4'h0;
    localparam logic [3:0] GRP_ENABLE = 4'h1;
    localparam logic [2:0] GRP_PRI = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_CPU_LVL = 8'h41;
    localparam logic [ADDR_W-1:0] ADDR_PEND = 8'h42;
    localparam logic [ADDR_W-1:0] ADDR_TRAP = 8'h43;
    localparam logic [ADDR_W-1:0] ADDR_OSC = 8'h44;
    // field positions
    localparam int ALT_SEL_BIT = 15;
    localparam int PEND_VEC_LSB = 0;
    localparam int PEND_LVL_LSB = 8;
    // reset values
    localparam logic [LVL_W-1:0] CPU_LVL_RST = 4'h0;
    localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
    // vector map, in program-memory word addresses
    localparam logic [PC_W-1:0] VEC_TABLE_BASE = 24'h000004;
    localparam logic [PC_W-1:0] ALT_TABLE_OFFSET = 24'h000100;
    localparam logic [PC_W-1:0] RESET_FETCH_ADDR = 24'h000000;
    localparam logic [VEC_W-1:0] SRC_VEC_FIRST = 7'h08;
    localparam int TRAP_OSC_FAIL = 1;
    localparam int TRAP_ADDR_ERR = 2;
    localparam int TRAP_STACK_ERR = 3;
    localparam int TRAP_MATH_ERR = 4;
    localparam logic [NUM_TRAPS-1:0] TRAP_IMPL_MASK = 8'h1e;
    localparam logic [LVL_W-1:0] TRAP_LVL_TOP = 4'hf;
    localparam logic [PRI_W-1:0] LVL_BLOCK_ALL = 3'h7;
    // fixed latencies in cycles
    localparam logic [3:0] ENTRY_LAT_CYC = 4'h4;
    localparam logic [3:0] RET_LAT_CYC = 4'h3;
    localparam logic [1:0] MON_ARM_CYC = 2'h3;

    typedef enum logic [1:0] {
        VIC_ST_BOOT,
        VIC_ST_IDLE,
        VIC_ST_ENTRY,
        VIC_ST_RETURN
    } vic_state_e;
endpackage
`default_nettype wire

// [verilog/vic_top.sv]
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// [R1] many requests become one vectored CPU request
// [R2] table at 000004h, 24-bit handler addresses
// [R3] 126 vectors: 8 traps, 118 sources
// [R4] equal requests: lower vector number wins
// [R5] seven user levels, natural order within
// [R6] fixed entry and return latency
// [R7] select bit uses alternate table
// [R8] alternate table sits 100h higher
// [R9] reset fetches from address zero
// [R10] trap vectors one to four fixed
// [R11] flag, enable, 3-bit priority per source
// [R12] software fills unused entries with reset handler
// [R13] software mirrors tables when alternate unused
// [R14] clock monitor switches to internal oscillator
// [R15] flags set by hardware, cleared by software
// [R16] accepted vector and level latched, readable
// [R17] CPU level seven blocks all user sources
// [R18] CPU level top bit read-only
// [R19] present only flagged, enabled, higher-priority sources
module vic_top import vic_pkg::*; #(
    parameter int NUM_SRC = 118
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // request sources
    input wire logic [NUM_SRC-1:0] i_src_req,
    input wire logic [2:0] i_trap_req,
    // clock monitor pins
    input wire logic i_clk_mon_en,
    input wire logic i_clk_valid,
    output logic o_fast_osc_sel,
    // cpu side
    output logic o_irq,
    output logic [VEC_W-1:0] o_irq_vec,
    input wire logic i_ack,
    input wire logic i_ret,
    output logic o_vec_go,
    output logic [PC_W-1:0] o_vec_addr,
    output logic o_ret_done,
    output logic o_boot_go
);
    localparam int ENTRY_DLY = int'(ENTRY_LAT_CYC);
    localparam int RET_DLY = int'(RET_LAT_CYC);

    vic_state_e state_q;
    logic [NUM_SRC-1:0] flag_q;
    logic [NUM_SRC-1:0] en_q;
    logic [PRI_W-1:0] prio_q [NUM_SRC];
    logic [NUM_TRAPS-1:0] trap_q;
    logic alt_sel_q;
    logic [LVL_W-1:0] lvl_q;
    logic [LVL_W-1:0] saved_lvl_q;
    logic [VEC_W-1:0] pend_vec_q;
    logic [LVL_W-1:0] pend_lvl_q;
    logic irq_q;
    logic [VEC_W-1:0] irq_vec_q;
    logic [LVL_W-1:0] irq_lvl_q;
    logic [3:0] cnt_q;
    logic [PC_W-1:0] vec_addr_q;
    logic [DATA_W-1:0] rdata_q;
    logic mon_en_m_q, mon_en_s_q, valid_m_q, valid_s_q;
    logic [1:0] mon_arm_q;
    logic fast_osc_q;

    logic cand_hit;
    logic cand_user;
    logic [VEC_W-1:0] cand_vec;
    logic [LVL_W-1:0] cand_lvl;
    logic [NUM_SRC-1:0] elig;
    logic accept;
    logic ret_end;
    logic osc_fail;
    logic wr_flag, wr_en, wr_pri;
    logic [NUM_TRAPS-1:0] trap_set;
    logic [DATA_W-1:0] rdata_d;

    assign wr_flag = i_wr && i_addr[7:4] == GRP_FLAG;
    assign wr_en = i_wr && i_addr[7:4] == GRP_ENABLE;
    assign wr_pri = i_wr && i_addr[7:5] == GRP_PRI;
    // an ack while a return runs is ignored, so level and sequencer stay in step
    assign accept = i_ack && irq_q && state_q == VIC_ST_IDLE;
    assign ret_end = state_q == VIC_ST_RETURN && cnt_q == 4'h0;

    //////////////////////////////////////////////////////////////////////////
    // per-source flag, enable and priority
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            flag_q <= '0;
        end else begin
            for (int s = 0; s < NUM_SRC; s++) begin
                if (wr_flag && s / SRC_PER_WORD == int'(i_addr[3:0])) begin
                    // writing 0 clears, a new request wins [R15]
                    flag_q[s] <= (flag_q[s] & i_wdata[s % SRC_PER_WORD]) | i_src_req[s];
                end else begin
                    flag_q[s] <= flag_q[s] | i_src_req[s]; // [R15]
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            en_q <= '0;
            for (int s = 0; s < NUM_SRC; s++) begin
                prio_q[s] <= '0;
            end
        end else begin
            for (int s = 0; s < NUM_SRC; s++) begin
                // one enable bit and one 3-bit field, by vector order [R11]
                if (wr_en && s / SRC_PER_WORD == int'(i_addr[3:0])) begin
                    en_q[s] <= i_wdata[s % SRC_PER_WORD];
                end
                if (wr_pri && s / SRC_PER_PRI == int'(i_addr[4:0])) begin
                    prio_q[s] <= i_wdata[PRI_FIELD_STRIDE * (s % SRC_PER_PRI) +: PRI_W];
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // clock failure monitor
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mon_en_m_q <= 1'b0;
            mon_en_s_q <= 1'b0;
            valid_m_q <= 1'b0;
            valid_s_q <= 1'b0;
            mon_arm_q <= 2'h0;
            fast_osc_q <= 1'b0;
        end else begin
            mon_en_m_q <= i_clk_mon_en;
            mon_en_s_q <= mon_en_m_q;
            valid_m_q <= i_clk_valid;
            valid_s_q <= valid_m_q;
            // checking starts once the synchronisers hold real pin levels
            if (mon_arm_q != MON_ARM_CYC) begin
                mon_arm_q <= mon_arm_q + 2'h1;
            end
            if (osc_fail) begin
                fast_osc_q <= 1'b1; // [R14]
            end
        end
    end

    assign osc_fail = mon_arm_q == MON_ARM_CYC && mon_en_s_q && !valid_s_q && !fast_osc_q;
    assign o_fast_osc_sel = fast_osc_q;

    //////////////////////////////////////////////////////////////////////////
    // trap flags
    always_comb begin
        trap_set = '0;
        trap_set[TRAP_OSC_FAIL] = osc_fail; // [R10] [R14]
        trap_set[TRAP_ADDR_ERR] = i_trap_req[0]; // [R10]
        trap_set[TRAP_STACK_ERR] = i_trap_req[1];
        trap_set[TRAP_MATH_ERR] = i_trap_req[2];
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            trap_q <= '0;
        end else if (i_wr && i_addr == ADDR_TRAP) begin
            trap_q <= ((trap_q & i_wdata[NUM_TRAPS-1:0]) | trap_set) & TRAP_IMPL_MASK;
        end else begin
            trap_q <= (trap_q | trap_set) & TRAP_IMPL_MASK;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // arbitration
    always_comb begin
        cand_hit = 1'b0;
        cand_user = 1'b0;
        cand_vec = '0;
        cand_lvl = '0;
        // traps outrank users; lower trap vector carries the higher level
        for (int t = 0; t < NUM_TRAPS; t++) begin
            if (!cand_hit && trap_q[t] && TRAP_LVL_TOP - LVL_W'(t) > lvl_q) begin
                cand_hit = 1'b1;
                cand_vec = VEC_W'(t);
                cand_lvl = TRAP_LVL_TOP - LVL_W'(t);
            end
        end
        for (int s = 0; s < NUM_SRC; s++) begin
            elig[s] = flag_q[s] && en_q[s] && !lvl_q[LVL_W-1] && lvl_q[PRI_W-1:0] != LVL_BLOCK_ALL
                && prio_q[s] > lvl_q[PRI_W-1:0]; // [R19] [R17]
        end
        if (!cand_hit) begin
            for (int s = 0; s < NUM_SRC; s++) begin
                // strict compare keeps the lowest vector on ties [R4] [R5]
                if (elig[s] && (!cand_user || {1'b0, prio_q[s]} > cand_lvl)) begin
                    cand_user = 1'b1;
                    cand_vec = SRC_VEC_FIRST + VEC_W'(s); // [R3]
                    cand_lvl = {1'b0, prio_q[s]};
                end
            end
            cand_hit = cand_user;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // request toward the cpu and fixed-latency sequencing
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            irq_q <= 1'b0;
            irq_vec_q <= '0;
            irq_lvl_q <= '0;
        end else begin
            irq_q <= cand_hit && state_q == VIC_ST_IDLE && !accept; // [R1]
            irq_vec_q <= cand_vec;
            irq_lvl_q <= cand_lvl;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q <= VIC_ST_BOOT;
            cnt_q <= '0;
            vec_addr_q <= RESET_FETCH_ADDR; // [R9]
        end else begin
            case (state_q)
                VIC_ST_BOOT: begin
                    state_q <= VIC_ST_IDLE;
                end
                VIC_ST_IDLE: begin
                    if (accept) begin
                        state_q <= VIC_ST_ENTRY;
                        cnt_q <= ENTRY_LAT_CYC - 4'h1; // [R6]
                        // word address of entry n is base + 2n [R2] [R7] [R8]
                        vec_addr_q <= VEC_TABLE_BASE + {16'h0000, irq_vec_q, 1'b0}
                            + (alt_sel_q ? ALT_TABLE_OFFSET : '0);
                    end else if (i_ret) begin
                        state_q <= VIC_ST_RETURN;
                        cnt_q <= RET_LAT_CYC - 4'h1; // [R6]
                    end
                end
                VIC_ST_ENTRY, VIC_ST_RETURN: begin
                    if (cnt_q == 4'h0) begin
                        state_q <= VIC_ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: begin
                    state_q <= VIC_ST_IDLE;
                end
            endcase
        end
    end

    assign o_irq = irq_q;
    assign o_irq_vec = irq_vec_q;
    assign o_vec_go = state_q == VIC_ST_ENTRY && cnt_q == 4'h0;
    assign o_vec_addr = vec_addr_q;
    assign o_ret_done = ret_end;
    assign o_boot_go = state_q == VIC_ST_BOOT; // [R9]

    //////////////////////////////////////////////////////////////////////////
    // control, cpu level and pending status
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            alt_sel_q <= 1'b0;
            lvl_q <= CPU_LVL_RST;
            saved_lvl_q <= CPU_LVL_RST;
            pend_vec_q <= '0;
            pend_lvl_q <= '0;
        end else begin
            if (i_wr && i_addr == ADDR_CTRL2) begin
                alt_sel_q <= i_wdata[ALT_SEL_BIT]; // [R7]
            end
            if (accept) begin
                saved_lvl_q <= lvl_q;
                lvl_q <= irq_lvl_q;
                pend_vec_q <= irq_vec_q; // [R16]
                pend_lvl_q <= irq_lvl_q;
            end else if (ret_end) begin
                lvl_q <= saved_lvl_q;
            end else if (i_wr && i_addr == ADDR_CPU_LVL) begin
                lvl_q[PRI_W-1:0] <= i_wdata[PRI_W-1:0]; // [R18]
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // register reads
    always_comb begin
        int k;
        rdata_d = '0;
        k = 0;
        if (i_addr[7:4] == GRP_FLAG || i_addr[7:4] == GRP_ENABLE) begin
            k = int'(i_addr[3:0]);
            for (int j = 0; j < SRC_PER_WORD; j++) begin
                if (k * SRC_PER_WORD + j < NUM_SRC) begin
                    rdata_d[j] = i_addr[4] ? en_q[k * SRC_PER_WORD + j] : flag_q[k * SRC_PER_WORD + j];
                end
            end
        end else if (i_addr[7:5] == GRP_PRI) begin
            k = int'(i_addr[4:0]);
            for (int j = 0; j < SRC_PER_PRI; j++) begin
                if (k * SRC_PER_PRI + j < NUM_SRC) begin
                    rdata_d[PRI_FIELD_STRIDE * j +: PRI_W] = prio_q[k * SRC_PER_PRI + j];
                end
            end
        end else if (i_addr == ADDR_CTRL2) begin
            rdata_d[ALT_SEL_BIT] = alt_sel_q;
        end else if (i_addr == ADDR_CPU_LVL) begin
            rdata_d[LVL_W-1:0] = lvl_q;
        end else if (i_addr == ADDR_PEND) begin
            rdata_d[PEND_VEC_LSB +: VEC_W] = pend_vec_q; // [R16]
            rdata_d[PEND_LVL_LSB +: LVL_W] = pend_lvl_q;
        end else if (i_addr == ADDR_TRAP) begin
            rdata_d[NUM_TRAPS-1:0] = trap_q;
        end else if (i_addr == ADDR_OSC) begin
            rdata_d[0] = fast_osc_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata_q <= REG_RST;
        end else begin
            rdata_q <= i_rd ? rdata_d : REG_RST;
        end
    end

    assign o_rdata = rdata_q;

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_irq_has_cause: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R1]
        o_irq |-> $past(cand_hit) && $past(state_q) == VIC_ST_IDLE)
        else $error("request raised without a pending candidate");

    a_entry_latency: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R6]
        accept |-> ##ENTRY_DLY o_vec_go)
        else $error("entry latency not fixed");

    a_return_latency: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R6]
        (state_q == VIC_ST_IDLE && i_ret && !accept) |-> ##RET_DLY o_ret_done)
        else $error("return latency not fixed");

    a_primary_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R2]
        (accept && !alt_sel_q) |=> vec_addr_q == VEC_TABLE_BASE + 24'(2 * int'(pend_vec_q)))
        else $error("primary vector address wrong");

    a_alt_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R8]
        (accept && alt_sel_q) |=> vec_addr_q == VEC_TABLE_BASE + ALT_TABLE_OFFSET + 24'(2 * int'(pend_vec_q)))
        else $error("alternate vector address wrong");

    a_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R15]
        (flag_q[0] && !wr_flag) |=> flag_q[0])
        else $error("request flag dropped without a write");

    a_level7_block: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R17]
        (cand_hit && lvl_q[PRI_W-1:0] == LVL_BLOCK_ALL) |-> cand_vec < SRC_VEC_FIRST)
        else $error("user source passed level seven");

    a_pending_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R16]
        accept |=> pend_vec_q == $past(irq_vec_q) && pend_lvl_q == $past(irq_lvl_q) && lvl_q == pend_lvl_q)
        else $error("pending status not latched");

    a_msb_readonly: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R18]
        (i_wr && i_addr == ADDR_CPU_LVL && !accept && !ret_end) |=> $stable(lvl_q[LVL_W-1]))
        else $error("software changed level top bit");

    a_natural_order: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R4]
        (cand_user && elig[0]) |-> cand_lvl > {1'b0, prio_q[0]} || cand_vec == SRC_VEC_FIRST)
        else $error("lower vector lost a tie");

    a_osc_switch: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R14]
        osc_fail |=> o_fast_osc_sel && trap_q[TRAP_OSC_FAIL])
        else $error("clock failure not handled");

    a_boot_fetch: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R9]
        o_boot_go |-> o_vec_addr == RESET_FETCH_ADDR ##1 !o_boot_go)
        else $error("reset fetch not at zero");

    c_user_taken: cover property (@(posedge i_sys_clk) disable iff (i_rst) accept && irq_vec_q >= SRC_VEC_FIRST);
    c_trap_taken: cover property (@(posedge i_sys_clk) disable iff (i_rst) accept && irq_vec_q < SRC_VEC_FIRST);
    c_alt_used: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_vec_go && alt_sel_q);
    c_returned: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_ret_done);
endmodule
`default_nettype wire

// [sim/vic_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module vic_cpu_model (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // controller side
    input wire logic i_irq,
    output logic o_ack,
    // pacing
    input wire logic [3:0] i_ack_wait
);
    logic [3:0] wait_q;
    // accept after a set number of request cycles
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_ack <= 1'b0;
            wait_q <= 4'h0;
        end else begin
            o_ack <= i_irq && !o_ack && wait_q == i_ack_wait;
            if (!i_irq || wait_q == i_ack_wait) begin
                wait_q <= 4'h0;
            end else if (!o_ack) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/vic_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module vic_top_tb import vic_pkg::*; ;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mon_en = 1'b0, clk_ok = 1'b1, ret = 1'b0, rd_d = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 16'h0000, rdata;
    logic [117:0] src = '0;
    logic [2:0] trap = 3'h0, p;
    logic [3:0] ack_wait = 4'h0;
    logic fast, irq, ack, vec_go, ret_done, boot, alt;
    logic [VEC_W-1:0] irq_vec;
    logic [PC_W-1:0] vec_addr;
    logic [30:0] exp_q[$], cur;
    logic [15:0] rd_q[$], pri_sh[0:29], en_sh[0:7];
    int err_count = 0, n_tests = 0, seed = 32'h04e38d4b, cyc = 0, acc_cyc = 0, ret_cyc = 0, s, a, b;

    vic_top #(.NUM_SRC(118)) i_vic_top (
        .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_src_req(src), .i_trap_req(trap), .i_clk_mon_en(mon_en),
        .i_clk_valid(clk_ok), .o_fast_osc_sel(fast), .o_irq(irq), .o_irq_vec(irq_vec),
        .i_ack(ack), .i_ret(ret), .o_vec_go(vec_go), .o_vec_addr(vec_addr),
        .o_ret_done(ret_done), .o_boot_go(boot)
    );
    vic_cpu_model i_vic_cpu_model (
        .i_sys_clk(clk), .i_rst(rst), .i_irq(irq), .o_ack(ack), .i_ack_wait(ack_wait)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wait_high(input int which);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 60 && !seen; i++) begin
            @(negedge clk);
            seen = ((which == 0) ? vec_go : (which == 1) ? ret_done : fast) === 1'b1;
        end
        check(seen, 1'b1);
        if (!seen) begin
            end_sim;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a_, input logic [15:0] d);
        @(posedge clk);
        addr <= a_;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a_, input logic [15:0] e);
        @(posedge clk);
        addr <= a_;
        rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic pulse(input logic [117:0] m, input logic [2:0] t);
        @(posedge clk);
        src <= m;
        trap <= t;
        @(posedge clk);
        src <= '0;
        trap <= 3'h0;
    endtask
    function automatic logic [117:0] bit_of(input int n);
        return 118'h1 << n;
    endfunction
    function automatic logic [15:0] clr(input int n);
        return ~(16'h1 << (n % 16));
    endfunction
    task automatic set_src(input int n, input logic [2:0] pr);
        pri_sh[n/4][4*(n%4)+:3] = pr;
        en_sh[n/16][n%16] = 1'b1;
        wr_reg(8'h20 + 8'(n/4), pri_sh[n/4]);
        wr_reg(8'h10 + 8'(n/16), en_sh[n/16]);
    endtask
    task automatic expect_vec(input int v, input logic alt_);
        // tables mirrored, unused entries on the reset handler
        exp_q.push_back({7'(v), VEC_TABLE_BASE + 24'(2*v) + (alt_ ? ALT_TABLE_OFFSET : 24'h0)});
    endtask
    task automatic service(input int v, input logic [3:0] l, input logic [7:0] ca, input logic [15:0] cd);
        wait_high(0);
        rd_reg(ADDR_PEND, {4'h0, l, 1'b0, 7'(v)});
        wr_reg(ca, cd);
        @(posedge clk);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        wait_high(1);
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (pri_sh[i]) pri_sh[i] = 16'h0000;
        foreach (en_sh[i]) en_sh[i] = 16'h0000;
        #1;
        check(boot, 1'b1);
        check(vec_addr, RESET_FETCH_ADDR);
        check(fast, 1'b0);
        @(posedge clk);
        #1;
        check(boot, 1'b0);
    endtask
    ////////////////////////////////////////
    // result watcher
    always @(posedge clk) begin
        if (rst) begin
            rd_d <= 1'b0;
        end else begin
            cyc++;
            if (rd_d) check(rdata, rd_q.pop_front());
            if (ack === 1'b1 && irq === 1'b1) begin
                acc_cyc = cyc;
                cur = exp_q.pop_front();
                check(irq_vec, cur[30:24]);
            end
            if (vec_go === 1'b1) begin
                check(vec_addr, cur[23:0]);
                check(cyc - acc_cyc, ENTRY_LAT_CYC);
            end
            if (ret === 1'b1) ret_cyc = cyc;
            if (ret_done === 1'b1) check(cyc - ret_cyc, RET_LAT_CYC);
            rd_d <= rd;
        end
    end
    ////////////////////////////////////////
    initial begin
        #400000;
        err_count++;
        end_sim;
    end
    initial begin
        do_reset;
        rd_reg(ADDR_CPU_LVL, 16'(CPU_LVL_RST));
        rd_reg(ADDR_CTRL2, REG_RST);
        wr_reg(8'h7f, 16'hffff);
        rd_reg(8'h7f, 16'h0000);
        s = $unsigned($random(seed)) % 118;
        pulse(bit_of(s), 3'h0);
        repeat (4) @(posedge clk);
        rd_reg(8'(s/16), 16'h1 << (s % 16));
        wr_reg(8'(s/16), clr(s));
        rd_reg(8'(s/16), 16'h0000);
        $display("registers and flags done");
        for (int k = 0; k < 4; k++) begin
            s = (k == 0) ? 0 : (k == 3) ? 117 : $unsigned($random(seed)) % 118;
            p = 3'($unsigned($random(seed)) % 7 + 1);
            alt = k[0];
            ack_wait <= 4'($unsigned($random(seed)) % 8);
            wr_reg(ADDR_CTRL2, alt ? 16'h8000 : 16'h0000);
            rd_reg(ADDR_CTRL2, alt ? 16'h8000 : 16'h0000);
            set_src(s, p);
            expect_vec(8 + s, alt);
            pulse(bit_of(s), 3'h0);
            service(8 + s, {1'b0, p}, 8'(s/16), clr(s));
        end
        wr_reg(ADDR_CTRL2, 16'h0000);
        $display("single sources done");
        a = $unsigned($random(seed)) % 100;
        b = a + 1 + $unsigned($random(seed)) % 17;
        for (int k = 0; k < 2; k++) begin
            set_src(a, k ? 3'h2 : 3'h3);
            set_src(b, k ? 3'h5 : 3'h3);
            expect_vec(k ? 8 + b : 8 + a, 1'b0);
            expect_vec(k ? 8 + a : 8 + b, 1'b0);
            pulse(bit_of(a) | bit_of(b), 3'h0);
            service(k ? 8 + b : 8 + a, k ? 4'h5 : 4'h3, 8'((k ? b : a)/16), clr(k ? b : a));
            service(k ? 8 + a : 8 + b, k ? 4'h2 : 4'h3, 8'((k ? a : b)/16), clr(k ? a : b));
        end
        $display("ordering done");
        wr_reg(ADDR_CPU_LVL, 16'h000f);
        rd_reg(ADDR_CPU_LVL, 16'h0007);
        set_src(a, 3'h7);
        pulse(bit_of(a), 3'h0);
        repeat (10) begin
            @(negedge clk);
            check(irq, 1'b0);
        end
        for (int t = 0; t < 3; t++) begin
            wr_reg(ADDR_CTRL2, (t == 1) ? 16'h8000 : 16'h0000);
            expect_vec(2 + t, t == 1);
            pulse(118'h0, 3'(1 << t));
            service(2 + t, 4'(13 - t), ADDR_TRAP, clr(2 + t));
        end
        wr_reg(ADDR_CTRL2, 16'h0000);
        expect_vec(8 + a, 1'b0);
        wr_reg(ADDR_CPU_LVL, 16'h0000);
        service(8 + a, 4'h7, 8'(a/16), clr(a));
        $display("masking and traps done");
        @(posedge clk);
        mon_en <= 1'b1;
        clk_ok <= 1'b0;
        expect_vec(1, 1'b0);
        do_reset;
        service(1, 4'he, ADDR_TRAP, clr(1));
        check(fast, 1'b1);
        rd_reg(ADDR_OSC, 16'h0001);
        repeat (4) @(posedge clk);
        check(exp_q.size(), 0);
        $display("clock monitor done");
        end_sim;
    end
endmodule
`default_nettype wire
